// >>> ifc_ms_tick.sv
`timescale 1ns/100ps
package ifc_pkg;
  // Clock and time base
  localparam int CLK_HZ      = 50_000_000;
  localparam int TICK_US     = 1000;
  localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
  // Register bus
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFF_CMD       = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PAYLOAD   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_RESP_CHAN = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_RESP_DATA = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 8'h10;
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  // Field positions
  localparam int CMD_WR_BIT     = 8;
  localparam int RESP_VALID_BIT = 31;
  localparam int SB_IND         = 0;
  localparam int SB_FLASH       = 1;
  localparam int SB_REPORT      = 2;
  localparam int SB_BUSY        = 3;
  localparam int SB_FULL        = 4;
  // Channel codes
  localparam int CHAN_W = 3;
  localparam logic [CHAN_W-1:0] CH_LEVEL  = 3'h0;
  localparam logic [CHAN_W-1:0] CH_FLASH  = 3'h1;
  localparam logic [CHAN_W-1:0] CH_ON     = 3'h2;
  localparam logic [CHAN_W-1:0] CH_OFF    = 3'h3;
  localparam logic [CHAN_W-1:0] CH_COUNT  = 3'h4;
  localparam logic [CHAN_W-1:0] CH_REPORT = 3'h5;
  // Payload values and reset values
  localparam logic signed [31:0] PL_ONE   = 32'sh1;
  localparam logic signed [31:0] PL_ZERO  = 32'sh0;
  localparam logic signed [31:0] CNT_INF  = -32'sh1;
  localparam logic signed [31:0] DEF_ON   = 32'sh1f4;
  localparam logic signed [31:0] DEF_OFF  = 32'sh1f4;
  localparam logic signed [31:0] DEF_CNT  = -32'sh1;
  localparam int                 Q_DEPTH  = 4;
  typedef enum logic [2:0] {
    FL_IDLE = 3'h1,
    FL_HIGH = 3'h2,
    FL_LOW  = 3'h4
  } ifc_state_t;
endpackage : ifc_pkg

module ifc_ms_tick #(
  parameter int unsigned CYCLES = ifc_pkg::TICK_CYCLES
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control
  input  wire logic clear,
  output logic      tick
);
  localparam int W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  assign tick  = (cnt_q == LAST) && !clear;
  assign cnt_d = (clear || tick) ? '0 : cnt_q + W'(1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule : ifc_ms_tick

// >>> ifc_top.sv
`timescale 1ns/100ps
// Functional notes
// [RQ1] Flash write of 1 starts flashing, then answers on the flash channel.
// [RQ2] Starting to flash overrides the steady indicator level.
// [RQ3] Flash write of 0 stops flashing and answers.
// [RQ4] Other flash payloads only produce an answer.
// [RQ5] Indicator high for on duration, low for off duration, in milliseconds.
// [RQ6] Durations update only on positive payloads.
// [RQ7] Negative cycle count flashes until a stop command.
// [RQ8] Positive count flashes that many cycles, then holds indicator low. A count of 0 flashes until a stop command.
// [RQ9] Each completed cycle decrements a non-negative count by one.
// [RQ10] Count reaching zero: set -1, stop, answer flash then count.
// [RQ11] Reporting set by 1, cleared by 0, others leave it.
// [RQ12] Reporting and flashing: answer indicator level at every transition.
// [RQ13] Parameter writes answer with the value after the write.
// [RQ14] Parameter reads answer with the current value.
// [RQ15] Flash answer is 1 while flashing, else 0.
// [RQ16] Level write 1 or 0 drives indicator and cancels flashing.
// [RQ17] Level answer is 1 when indicator high, else 0.
// [RQ18] Reads on any channel answer and change nothing.
// [RQ19] A millisecond tick derived from the clock times the phases.
// [RQ20] Flashing starts in the high phase with timing from zero.
// [RQ21] Answers due together are queued and emitted in turn.
module ifc_top #(
  parameter int unsigned      TICK_CYCLES = ifc_pkg::TICK_CYCLES,
  parameter logic signed [31:0] RST_ON    = ifc_pkg::DEF_ON,
  parameter logic signed [31:0] RST_OFF   = ifc_pkg::DEF_OFF,
  parameter logic signed [31:0] RST_CNT   = ifc_pkg::DEF_CNT,
  parameter int unsigned      DEPTH       = ifc_pkg::Q_DEPTH
) (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // AXI4-Lite write address and data
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [ifc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                s_axi_awprot,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  // AXI4-Lite write response
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  output logic [1:0]                     s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  input  wire logic [ifc_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                s_axi_arprot,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  // Indicator pin
  output logic                           onboard_indicator
);
  localparam int AW = ifc_pkg::ADDR_W;
  localparam int CW = ifc_pkg::CHAN_W;
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] DEPTH_C = (PW + 1)'(DEPTH);

  // Bus state
  logic          aw_hold_q;
  logic [AW-1:0] aw_addr_q;
  logic          w_hold_q;
  logic [31:0]   w_data_q;
  logic [3:0]    w_strb_q;
  logic          bvalid_q;
  logic [1:0]    bresp_q;
  logic          rvalid_q;
  logic [31:0]   rdata_q;
  logic [1:0]    rresp_q;
  logic [31:0]   payload_q;

  // Flash engine state
  ifc_pkg::ifc_state_t state_q, state_d;
  logic [31:0]         phase_q, phase_d;
  logic                ind_q, ind_d;
  logic signed [31:0]  on_q, on_d;
  logic signed [31:0]  off_q, off_d;
  logic signed [31:0]  cnt_q, cnt_d;
  logic                rep_q, rep_d;
  logic                set_flash, set_count, set_level, tick_clear;

  // Pending answers and queue
  logic          p_cmd_q, p_flash_q, p_count_q, p_level_q;
  logic [CW-1:0] cmd_chan_q;
  logic [CW+31:0] mem_q [DEPTH];
  logic [PW-1:0] wr_ptr_q, rd_ptr_q;
  logic [PW:0]   fill_q;

  function automatic logic [31:0] resp_value(input logic [CW-1:0] ch);
    logic [31:0] v;
    v = '0;
    case (ch)
      ifc_pkg::CH_LEVEL:  v = {31'h0, ind_q};                    // RQ17
      ifc_pkg::CH_FLASH:  v = {31'h0, state_q != ifc_pkg::FL_IDLE}; // RQ15
      ifc_pkg::CH_ON:     v = on_q;                              // RQ14
      ifc_pkg::CH_OFF:    v = off_q;
      ifc_pkg::CH_COUNT:  v = cnt_q;
      ifc_pkg::CH_REPORT: v = {31'h0, rep_q};
      default:            v = '0;
    endcase
    return v;
  endfunction : resp_value

  function automatic logic hit(input logic [AW-1:0] a,
                               input logic [AW-1:0] off);
    return a[AW-1:2] == off[AW-1:2];
  endfunction : hit

  // Millisecond time base
  logic ms_tick;
  ifc_ms_tick #(.CYCLES(TICK_CYCLES)) ifc_ms_tick_inst (
    .aclk    (aclk),
    .aresetn (aresetn),
    .clear   (tick_clear),
    .tick    (ms_tick)
  ); // RQ19

  // Write channel decode
  wire do_write  = aw_hold_q && w_hold_q && !bvalid_q;
  wire wr_cmd    = do_write && hit(aw_addr_q, ifc_pkg::OFF_CMD);
  wire wr_pay    = do_write && hit(aw_addr_q, ifc_pkg::OFF_PAYLOAD);
  wire wr_ok     = hit(aw_addr_q, ifc_pkg::OFF_PAYLOAD) ||
                   (hit(aw_addr_q, ifc_pkg::OFF_CMD) && !p_cmd_q);
  // A command is refused while its previous answer is still pending
  wire cmd_fire  = wr_cmd && !p_cmd_q;
  wire [CW-1:0] cmd_chan = w_data_q[CW-1:0];
  wire cmd_wr    = w_data_q[ifc_pkg::CMD_WR_BIT];
  wire signed [31:0] pl = payload_q;
  wire pl_bin    = (pl == ifc_pkg::PL_ONE) || (pl == ifc_pkg::PL_ZERO);

  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready  = !w_hold_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // Read channel decode
  wire ar_take   = s_axi_arvalid && !rvalid_q;
  wire q_empty   = (fill_q == '0);
  wire q_full    = (fill_q == DEPTH_C);
  wire pop       = ar_take && !q_empty &&
                   hit(s_axi_araddr, ifc_pkg::OFF_RESP_DATA);
  wire [CW+31:0] q_head = mem_q[rd_ptr_q];
  wire ar_known  = hit(s_axi_araddr, ifc_pkg::OFF_CMD) ||
                   hit(s_axi_araddr, ifc_pkg::OFF_PAYLOAD) ||
                   hit(s_axi_araddr, ifc_pkg::OFF_RESP_CHAN) ||
                   hit(s_axi_araddr, ifc_pkg::OFF_RESP_DATA) ||
                   hit(s_axi_araddr, ifc_pkg::OFF_STATUS);
  wire [31:0] status_word =
    (32'h1 << ifc_pkg::SB_IND)    & {32{ind_q}} |
    (32'h1 << ifc_pkg::SB_FLASH)  & {32{state_q != ifc_pkg::FL_IDLE}} |
    (32'h1 << ifc_pkg::SB_REPORT) & {32{rep_q}} |
    (32'h1 << ifc_pkg::SB_BUSY)   & {32{p_cmd_q}} |
    (32'h1 << ifc_pkg::SB_FULL)   & {32{q_full}};
  wire [31:0] rd_word =
    hit(s_axi_araddr, ifc_pkg::OFF_PAYLOAD)   ? payload_q :
    hit(s_axi_araddr, ifc_pkg::OFF_RESP_CHAN) ?
      ({32{!q_empty}} & ((32'h1 << ifc_pkg::RESP_VALID_BIT) |
                         {{(32-CW){1'b0}}, q_head[CW+31:32]})) :
    hit(s_axi_araddr, ifc_pkg::OFF_RESP_DATA) ?
      ({32{!q_empty}} & q_head[31:0]) :
    hit(s_axi_araddr, ifc_pkg::OFF_STATUS)    ? status_word : 32'h0;

  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign onboard_indicator = ind_q;

  // Answer arbitration: flash status is served before cycle count
  wire any_pend  = p_cmd_q || p_flash_q || p_count_q || p_level_q;
  wire push      = any_pend && !q_full; // RQ21
  wire [CW-1:0] sel_chan = p_cmd_q   ? cmd_chan_q :
                           p_flash_q ? ifc_pkg::CH_FLASH :
                           p_count_q ? ifc_pkg::CH_COUNT :
                                       ifc_pkg::CH_LEVEL; // RQ10
  wire clr_cmd   = push && p_cmd_q;
  wire clr_flash = push && !p_cmd_q && p_flash_q;
  wire clr_count = push && !p_cmd_q && !p_flash_q && p_count_q;
  wire clr_level = push && !p_cmd_q && !p_flash_q && !p_count_q;

  wire [31:0] phase_inc = phase_q + 32'h1;
  wire [31:0] dur = (state_q == ifc_pkg::FL_HIGH) ? on_q : off_q;
  wire signed [31:0] cnt_dec = cnt_q - 32'sh1;

  // Flash engine next state; a write command wins over a tick in the same cycle
  always_comb begin
    state_d    = state_q;
    phase_d    = phase_q;
    ind_d      = ind_q;
    on_d       = on_q;
    off_d      = off_q;
    cnt_d      = cnt_q;
    rep_d      = rep_q;
    set_flash  = 1'b0;
    set_count  = 1'b0;
    set_level  = 1'b0;
    tick_clear = 1'b0;
    if (cmd_fire && cmd_wr) begin // RQ18
      case (cmd_chan)
        ifc_pkg::CH_LEVEL: begin
          if (pl_bin) begin
            ind_d   = pl[0];
            state_d = ifc_pkg::FL_IDLE; // RQ16
          end
        end
        ifc_pkg::CH_FLASH: begin
          if (pl == ifc_pkg::PL_ONE) begin
            state_d    = ifc_pkg::FL_HIGH; // RQ1
            phase_d    = '0;               // RQ20
            ind_d      = 1'b1;             // RQ2
            tick_clear = 1'b1;
            set_level  = rep_q;            // RQ12
          end else if (pl == ifc_pkg::PL_ZERO) begin
            state_d = ifc_pkg::FL_IDLE;    // RQ3
            ind_d   = 1'b0;
          end // RQ4
          // Any other payload only answers, with no other effect
        end
        ifc_pkg::CH_ON: begin
          if (pl > ifc_pkg::PL_ZERO) begin
            on_d = pl; // RQ6
          end
        end
        ifc_pkg::CH_OFF: begin
          if (pl > ifc_pkg::PL_ZERO) begin
            off_d = pl; // RQ6
          end
        end
        ifc_pkg::CH_COUNT: begin
          cnt_d = pl; // RQ7
        end
        ifc_pkg::CH_REPORT: begin
          if (pl_bin) begin
            rep_d = pl[0]; // RQ11
          end
        end
        default: begin
        end
      endcase
    end else if (ms_tick && state_q != ifc_pkg::FL_IDLE) begin
      if (phase_inc >= dur) begin // RQ5
        phase_d = '0;
        if (state_q == ifc_pkg::FL_HIGH) begin
          state_d   = ifc_pkg::FL_LOW;
          ind_d     = 1'b0;
          set_level = rep_q; // RQ12
        end else if (!cnt_q[31] && cnt_dec == ifc_pkg::PL_ZERO) begin
          cnt_d     = ifc_pkg::CNT_INF;  // RQ10
          state_d   = ifc_pkg::FL_IDLE;  // RQ8
          set_flash = 1'b1;
          set_count = 1'b1;
        end else begin
          if (!cnt_q[31]) begin
            cnt_d = cnt_dec; // RQ9
          end
          state_d   = ifc_pkg::FL_HIGH;
          ind_d     = 1'b1;
          set_level = rep_q; // RQ12
        end
      end else begin
        phase_d = phase_inc;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= ifc_pkg::FL_IDLE;
      phase_q <= '0;
      ind_q   <= 1'b0;
      on_q    <= RST_ON;
      off_q   <= RST_OFF;
      cnt_q   <= RST_CNT;
      rep_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      ind_q   <= ind_d;
      on_q    <= on_d;
      off_q   <= off_d;
      cnt_q   <= cnt_d;
      rep_q   <= rep_d;
    end
  end

  // Pending answers: a new request always wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p_cmd_q    <= 1'b0;
      p_flash_q  <= 1'b0;
      p_count_q  <= 1'b0;
      p_level_q  <= 1'b0;
      cmd_chan_q <= ifc_pkg::CH_LEVEL;
    end else begin
      p_cmd_q   <= cmd_fire  || (p_cmd_q   && !clr_cmd); // RQ13
      p_flash_q <= set_flash || (p_flash_q && !clr_flash);
      p_count_q <= set_count || (p_count_q && !clr_count);
      p_level_q <= set_level || (p_level_q && !clr_level);
      if (cmd_fire) begin
        cmd_chan_q <= cmd_chan;
      end
    end
  end

  // Answer queue; values are sampled when an answer enters it
  always_ff @(posedge aclk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= {sel_chan, resp_value(sel_chan)}; // RQ13
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      fill_q   <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + PW'(1);
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + PW'(1);
      end
      fill_q <= fill_q + (PW + 1)'(push) - (PW + 1)'(pop); // RQ21
    end
  end

  // AXI4-Lite write path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_hold_q  <= 1'b0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
      bvalid_q  <= 1'b0;
      bresp_q   <= ifc_pkg::AXI_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_hold_q) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && !w_hold_q) begin
        w_hold_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold_q <= 1'b0;
      end
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? ifc_pkg::AXI_OKAY : ifc_pkg::AXI_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Payload holding register honours byte strobes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      payload_q <= '0;
    end else if (wr_pay) begin
      for (int i = 0; i < 4; i++) begin
        if (w_strb_q[i]) begin
          payload_q[8*i +: 8] <= w_data_q[8*i +: 8];
        end
      end
    end
  end

  // AXI4-Lite read path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= ifc_pkg::AXI_OKAY;
    end else if (ar_take) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_word;
      rresp_q  <= ar_known ? ifc_pkg::AXI_OKAY : ifc_pkg::AXI_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end
endmodule : ifc_top

// >>> ifc_top_sva.sv
`timescale 1ns/100ps
module ifc_top_sva (
  // Clock and reset
  input wire logic                       aclk,
  input wire logic                       aresetn,
  // Write channels
  input wire logic                       s_axi_awvalid,
  input wire logic                       s_axi_awready,
  input wire logic                       s_axi_wvalid,
  input wire logic                       s_axi_wready,
  input wire logic                       s_axi_bvalid,
  input wire logic                       s_axi_bready,
  input wire logic [1:0]                 s_axi_bresp,
  // Read channels
  input wire logic                       s_axi_arvalid,
  input wire logic                       s_axi_arready,
  input wire logic [ifc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic                       s_axi_rvalid,
  input wire logic                       s_axi_rready,
  input wire logic [31:0]                s_axi_rdata,
  input wire logic [1:0]                 s_axi_rresp,
  // Indicator
  input wire logic                       onboard_indicator
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wr_done;
    !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid;
  endsequence
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  wr_answer_a: assert property (wr_both |=> wr_done)
    else $error("write answer late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
    else $error("rvalid dropped");
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  rd_unmapped_a: assert property ((rd_take and (s_axi_araddr > 8'h13)) |=>
    s_axi_rresp == ifc_pkg::AXI_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  status_level_a: assert property (
    (rd_take and (s_axi_araddr == ifc_pkg::OFF_STATUS)) |=>
    s_axi_rdata[ifc_pkg::SB_IND] == $past(onboard_indicator))
    else $error("status level wrong");
  reset_dark_a: assert property ($rose(aresetn) |->
    !onboard_indicator && !s_axi_bvalid && !s_axi_rvalid)
    else $error("reset state wrong");
  // Phase edges come a whole tick apart; a command may move the level
  // on any edge, and its write answer rises with it, so it is excused
  ind_spacing_a: assert property (
    $changed(onboard_indicator) && !s_axi_bvalid |=>
    ($stable(onboard_indicator) || s_axi_bvalid)[*2])
    else $error("indicator glitch");
endmodule : ifc_top_sva

bind ifc_top ifc_top_sva ifc_top_sva_inst (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_rresp, .onboard_indicator);

// >>> ifc_host_model.sv
`timescale 1ns/100ps
module ifc_host_model (
  // Clock
  input  wire logic        aclk,
  // Write channels
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [7:0]       s_axi_awaddr,
  output logic [2:0]       s_axi_awprot,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  output logic [31:0]      s_axi_wdata,
  output logic [3:0]       s_axi_wstrb,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  // Read channels
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  output logic [7:0]       s_axi_araddr,
  output logic [2:0]       s_axi_arprot,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
  end
  // Leading edge keeps a strobe from being set twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
    s_axi_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : ifc_host_model

// >>> indicator_flash_controller_test.sv
`timescale 1ns/100ps
module indicator_flash_controller_test;
  localparam int T = 10;
  localparam logic [1:0] OK = ifc_pkg::AXI_OKAY;
  logic        aclk, aresetn, onboard_indicator;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, s_axi_rdata, on_ms;
  logic [33:0] note_q[$];
  logic [33:0] got, exp;
  logic [31:0] rst_v[6] = '{32'h0, 32'h0, ifc_pkg::DEF_ON,
                            ifc_pkg::DEF_OFF, ifc_pkg::DEF_CNT, 32'h0};
  int          err_total, tests_run, n;
  ifc_top #(.TICK_CYCLES(T)) ifc_top_inst (.aclk, .aresetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_araddr, .s_axi_arprot, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .onboard_indicator);
  ifc_host_model ifc_host_model_inst (.aclk, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_awprot, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_rvalid, .s_axi_rready);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic conclude();
    $display("mismatches %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude
  // Monitor: every bus answer is matched against the oldest note
  always @(posedge aclk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
      got = {s_axi_rresp, s_axi_rdata};
      exp = note_q.size() ? note_q.pop_front() : 'x;
      chk(got, exp);
    end
    if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
      got = {s_axi_bresp, 32'h0};
      exp = note_q.size() ? note_q.pop_front() : 'x;
      chk(got, exp);
    end
  end
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    note_q.push_back(e);
    ifc_host_model_inst.rd(a);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    note_q.push_back({r, 32'h0});
    ifc_host_model_inst.wr(a, d);
  endtask : wr
  task automatic cmd(input logic [2:0] ch, input logic w,
                     input logic [31:0] pl);
    wr(ifc_pkg::OFF_PAYLOAD, pl, OK);
    wr(ifc_pkg::OFF_CMD, {23'h0, w, 5'h0, ch}, OK);
  endtask : cmd
  task automatic pop(input logic [2:0] ch, input logic [31:0] pl);
    rd(ifc_pkg::OFF_RESP_CHAN, {OK, 1'b1, 28'h0, ch});
    rd(ifc_pkg::OFF_RESP_DATA, {OK, pl});
  endtask : pop
  // Length in cycles of the phase at level lvl; call at or before its start
  task automatic width(input logic lvl, output int w);
    w = 0;
    while (onboard_indicator !== lvl) @(posedge aclk);
    do begin
      w++;
      @(posedge aclk);
    end while (onboard_indicator === lvl);
  endtask : width
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    conclude();
  end
  initial begin
    err_total = 0;
    tests_run = 0;
    aresetn = 1'b0;
    void'($urandom(42));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int c = 0; c < 6; c++) begin
      cmd(3'(c), 1'b0, $urandom);
      pop(3'(c), rst_v[c]);
    end
    rd(ifc_pkg::OFF_STATUS, {OK, 32'h0});
    rd(8'h20, {ifc_pkg::AXI_SLVERR, 32'h0});
    wr(8'h24, 32'h1, ifc_pkg::AXI_SLVERR);
    on_ms = $urandom_range(4, 2);
    cmd(ifc_pkg::CH_ON, 1'b1, on_ms);
    pop(ifc_pkg::CH_ON, on_ms);
    cmd(ifc_pkg::CH_ON, 1'b1, 32'h0);
    pop(ifc_pkg::CH_ON, on_ms);
    cmd(ifc_pkg::CH_ON, 1'b1, -32'sd5);
    pop(ifc_pkg::CH_ON, on_ms);
    cmd(ifc_pkg::CH_OFF, 1'b1, 32'h8);
    pop(ifc_pkg::CH_OFF, 32'h8);
    cmd(ifc_pkg::CH_REPORT, 1'b1, 32'h1);
    pop(ifc_pkg::CH_REPORT, 32'h1);
    cmd(ifc_pkg::CH_REPORT, 1'b1, 32'h7);
    pop(ifc_pkg::CH_REPORT, 32'h1);
    cmd(ifc_pkg::CH_LEVEL, 1'b1, 32'h0);
    pop(ifc_pkg::CH_LEVEL, 32'h0);
    // Flash from a steady low level, reporting every edge
    cmd(ifc_pkg::CH_FLASH, 1'b1, 32'h1);
    pop(ifc_pkg::CH_FLASH, 32'h1);
    pop(ifc_pkg::CH_LEVEL, 32'h1);
    width(1'b0, n);
    chk(34'(n), 34'(8 * T));
    width(1'b1, n);
    chk(34'(n), 34'(on_ms * T));
    pop(ifc_pkg::CH_LEVEL, 32'h0);
    pop(ifc_pkg::CH_LEVEL, 32'h1);
    pop(ifc_pkg::CH_LEVEL, 32'h0);
    cmd(ifc_pkg::CH_FLASH, 1'b1, 32'h5);
    pop(ifc_pkg::CH_FLASH, 32'h1);
    cmd(ifc_pkg::CH_FLASH, 1'b1, 32'h0);
    pop(ifc_pkg::CH_FLASH, 32'h0);
    chk(34'(onboard_indicator), 34'h0);
    cmd(ifc_pkg::CH_REPORT, 1'b1, 32'h0);
    pop(ifc_pkg::CH_REPORT, 32'h0);
    // Two counted cycles, then a self stop
    cmd(ifc_pkg::CH_COUNT, 1'b1, 32'h2);
    pop(ifc_pkg::CH_COUNT, 32'h2);
    cmd(ifc_pkg::CH_FLASH, 1'b1, 32'h1);
    pop(ifc_pkg::CH_FLASH, 32'h1);
    repeat (2 * (on_ms + 8) * T) @(posedge aclk);
    pop(ifc_pkg::CH_FLASH, 32'h0);
    pop(ifc_pkg::CH_COUNT, ifc_pkg::CNT_INF);
    n = 0;
    repeat ((on_ms + 8) * T) begin
      @(posedge aclk);
      n += onboard_indicator;
    end
    chk(34'(n), 34'h0);
    // Endless flashing cut short by a level write
    cmd(ifc_pkg::CH_FLASH, 1'b1, 32'h1);
    pop(ifc_pkg::CH_FLASH, 32'h1);
    rd(ifc_pkg::OFF_STATUS, {OK, 32'h3});
    repeat (2 * (on_ms + 8) * T) @(posedge aclk);
    cmd(ifc_pkg::CH_FLASH, 1'b0, $urandom);
    pop(ifc_pkg::CH_FLASH, 32'h1);
    cmd(ifc_pkg::CH_LEVEL, 1'b1, 32'h1);
    pop(ifc_pkg::CH_LEVEL, 32'h1);
    cmd(ifc_pkg::CH_FLASH, 1'b0, 32'h0);
    pop(ifc_pkg::CH_FLASH, 32'h0);
    rd(ifc_pkg::OFF_STATUS, {OK, 32'h1});
    conclude();
  end
endmodule : indicator_flash_controller_test
